// ===== shared/sol_link_if.sv
// Purpose: Primary and secondary pins between sensor and controller
// Assumes: Both lines are pulled low when nobody drives them
// Notes:   Device wins if both ends drive at once
`timescale 1ns/1ps
interface sol_link_if;
   logic pri_dev_o;
   logic pri_dev_oe;
   logic pri_host_o;
   logic pri_host_oe;
   logic sec_dev_o;
   logic sec_dev_oe;
   logic sec_host_o;
   logic sec_host_oe;
   logic pri_line;
   logic sec_line;
   assign pri_line = pri_dev_oe ? pri_dev_o : (pri_host_oe & pri_host_o);
   assign sec_line = sec_dev_oe ? sec_dev_o : (sec_host_oe & sec_host_o);
   modport dev (output pri_dev_o, pri_dev_oe, sec_dev_o, sec_dev_oe,
                input pri_host_oe, sec_line);
   modport host (output pri_host_o, pri_host_oe, sec_host_o, sec_host_oe,
                 input pri_line, sec_line, sec_dev_o, sec_dev_oe);
endinterface

// ===== shared/sol_pkg.sv
// Purpose: Shared constants and types of the switching output logic
// Assumes: 25 MHz system clock on both ends
// Notes:   Timing counts are derived from times in their own units
package sol_pkg;
   localparam int MEAS_W       = 16;
   localparam int CLK_HZ       = 25_000_000;
   localparam int BOOL_DLY_MS  = 2;
   localparam int BOOL_DLY_CYC = CLK_HZ / 1000 * BOOL_DLY_MS;
   localparam int HS_US        = 100;
   localparam int HS_CYC       = CLK_HZ / 1_000_000 * HS_US;
   localparam int WAKE_US      = 80;
   localparam int WAKE_CYC     = CLK_HZ / 1_000_000 * WAKE_US;
   localparam int BREQ_US      = 100;
   localparam int BREQ_CYC     = CLK_HZ / 1_000_000 * BREQ_US;
   localparam int BTMO_US      = 1000;
   localparam int BTMO_CYC     = CLK_HZ / 1_000_000 * BTMO_US;
   // Factory setpoints
   localparam logic [MEAS_W-1:0] SP1_DEF = 16'h0800;
   localparam logic [MEAS_W-1:0] SP2_DEF = 16'h0400;
   // Controller register map
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam int CTRL_WAKE    = 0;
   localparam int CTRL_BITREQ  = 1;
   localparam int CTRL_SEC_DRV = 2;
   localparam int CTRL_SEC_LVL = 3;
   localparam int ST_PRI_LVL   = 0;
   localparam int ST_SEC_LVL   = 1;
   localparam int ST_BIT_DONE  = 2;
   localparam int ST_BIT_PRES  = 3;
   localparam int ST_BIT_FAIL  = 4;
   localparam int ST_BUSY      = 5;
   typedef enum logic [1:0] {SOL_SINGLE, SOL_WINDOW, SOL_HYST} sol_mode_t;
   typedef enum logic [2:0] {
      SOL_SEC_OFF, SOL_SEC_OUT, SOL_SEC_AND, SOL_SEC_OR,
      SOL_SEC_BIT, SOL_SEC_TEACH
   } sol_sec_t;
   typedef enum logic [1:0] {SOL_H_IDLE, SOL_H_WAKE, SOL_H_REQ,
      SOL_H_WAIT} sol_hst_t;
endpackage

// ===== tb/sol_link_monitor.sv
// Purpose: Wire checks on the link between sensor and controller ends
// Assumes: One clock, reset active high
// Notes:   Sees only the link, so checks are pulse lengths and order
`timescale 1ns/1ps
module sol_link_monitor
   import sol_pkg::*;
(
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_RST,
   // Link lines
   input wire logic pri_dev_oe,
   input wire logic pri_host_oe,
   input wire logic sec_dev_oe,
   input wire logic sec_host_o,
   input wire logic sec_host_oe
);
   logic [15:0] wake_q, breq_q, hs_q;
   logic [7:0]  gap_q;
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_RST);
   // Gap saturates so a late drop can never look like a fresh wake-up
   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         wake_q <= 16'h0;
         breq_q <= 16'h0;
         hs_q   <= 16'h0;
         gap_q  <= 8'hff;
      end else begin
         wake_q <= pri_host_oe ? wake_q + 16'h1 : 16'h0;
         breq_q <= sec_host_oe ? breq_q + 16'h1 : 16'h0;
         hs_q   <= sec_dev_oe ? hs_q + 16'h1 : 16'h0;
         if (pri_host_oe)
            gap_q <= 8'h0;
         else if (gap_q != 8'hff)
            gap_q <= gap_q + 8'h1;
      end
   end
   a_wake_width: assert property (
      $fell(pri_host_oe) |-> wake_q == WAKE_CYC)
      else $error("wake pulse length wrong");
   a_iolink_entry: assert property (
      $fell(pri_host_oe) |-> ##[1:8] !pri_dev_oe)
      else $error("no change to link mode after wake");
   a_iolink_hold: assert property (
      !pri_dev_oe |=> !pri_dev_oe)
      else $error("primary switching output came back");
   a_sio_start: assert property (
      $fell(I_RST) |-> pri_dev_oe)
      else $error("primary output not driven after reset");
   a_sio_hold: assert property (
      $fell(pri_dev_oe) |-> gap_q < 8'ha)
      else $error("primary output dropped without wake");
   a_breq_width: assert property (
      $fell(sec_host_oe) && $past(sec_host_o) |-> breq_q == BREQ_CYC)
      else $error("test request length wrong");
   a_hs_width: assert property (
      $fell(sec_dev_oe) |-> hs_q == HS_CYC)
      else $error("handshake length wrong");
   a_no_contend: assert property (
      !(sec_dev_oe && sec_host_oe))
      else $error("both ends drive the second pin");
endmodule // sol_link_monitor

// ===== tb/switching_output_logic_tb.sv
// Purpose: Bench for the sensor end joined to the controller end
// Assumes: Controller registers reached over APB on the same clock
// Notes:   Boolean filter shortened to BC clocks; pin-2 output runs last
`timescale 1ns/1ps
module switching_output_logic_tb;
   import sol_pkg::*;
   localparam int BC = 20;
   localparam logic [15:0] HI = 16'h0100;
   localparam sol_mode_t TM [11] = '{SOL_SINGLE, SOL_SINGLE, SOL_WINDOW,
      SOL_WINDOW, SOL_WINDOW, SOL_WINDOW, SOL_HYST, SOL_HYST, SOL_HYST,
      SOL_HYST, SOL_HYST};
   localparam logic [15:0] TV [11] = '{16'h0100, 16'h00ff, 16'h0150,
      16'h0250, 16'h0050, 16'h0200, 16'h0250, 16'h0150, 16'h0100,
      16'h0150, 16'h0200};
   localparam logic [10:0] TE = 11'h325;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, er, iol, chan;
   logic [15:0] meas = 16'h0;
   logic [15:0] osp1, osp2;
   logic [15:0] sp_a = 16'h0100, sp_b = 16'h0200, dlyc = 16'h000a;
   sol_mode_t   mode = SOL_SINGLE;
   sol_sec_t    smode = SOL_SEC_OFF;
   logic        inv = 1'b0;
   logic        dly = 1'b0;
   logic        str = 1'b0;
   logic        os = 1'b0;
   logic        trail = 1'b0;
   logic        spwr = 1'b0;
   int          fails = 0;
   int          comparisons = 0;
   int          n;
   sol_link_if link ();
   sol_dev #(.CNT_W(16), .BOOL_CYC(BC)) sol_dev_i (
      .I_MCLK(mclk), .I_RST(rst), .LINK(link.dev), .I_MEAS(meas),
      .I_MODE(mode), .I_INVERT(inv), .I_DLY_EN(dly), .I_STR_EN(str),
      .I_OS_EN(os), .I_OS_TRAIL(trail), .I_DLY_CNT(dlyc),
      .I_STR_CNT(16'h0028), .I_OS_CNT(16'h0005), .I_SEC_MODE(smode),
      .I_SP_WR(spwr), .I_SP1(sp_a), .I_SP2(sp_b), .O_SP1(osp1),
      .O_SP2(osp2), .O_IOLINK(iol), .O_CHAN(chan));
   sol_host #(.TMO_CYC(3000)) sol_host_i (
      .I_MCLK(mclk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .LINK(link.host));
   sol_link_monitor sol_link_monitor_i (
      .I_MCLK(mclk), .I_RST(rst), .pri_dev_oe(link.pri_dev_oe),
      .pri_host_oe(link.pri_host_oe), .sec_dev_oe(link.sec_dev_oe),
      .sec_host_o(link.sec_host_o), .sec_host_oe(link.sec_host_oe));
   always #20 mclk = ~mclk;
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Waits on pready even though this slave answers at once
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge mclk);
      pen <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
   endtask
   task automatic hcount;
      n = 0;
      repeat (30) begin
         @(posedge mclk);
         n += int'(link.pri_line === 1'b1);
      end
   endtask
   task automatic bit_run;
      bus(1'b1, OFS_CTRL, 32'h2);
      n = 0;
      do begin
         cyc(20);
         bus(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while ((rd[ST_BUSY] !== 1'b0 || rd[ST_BIT_DONE] !== 1'b1)
                 && n < 600);
      chk(rd[ST_BIT_DONE], 1'b1);
      // Let the sensor's answer end before the next request is made
      cyc(HS_CYC + 8);
   endtask
   task automatic stop_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #(40 * 60000);
      fails++;
      stop_test();
   end
   initial begin
      cyc(8);
      rst <= 1'b0;
      cyc(2);
      chk(osp1, SP1_DEF);
      chk(osp2, SP2_DEF);
      chk(iol, 1'b0);
      meas <= SP1_DEF;
      cyc(6);
      chk(link.pri_line, 1'b1);
      spwr <= 1'b1;
      cyc(1);
      spwr <= 1'b0;
      cyc(2);
      chk(osp1, 16'h0100);
      for (int i = 0; i < 11; i++) begin
         mode <= TM[i];
         meas <= TV[i];
         cyc(3);
         chk(chan, TE[i]);
      end
      mode <= SOL_SINGLE;
      meas <= HI;
      inv  <= 1'b1;
      cyc(6);
      chk(link.pri_line, 1'b0);
      meas <= 16'h0;
      inv  <= 1'b0;
      dly  <= 1'b1;
      cyc(20);
      meas <= HI;
      cyc(5);
      meas <= 16'h0;
      hcount();
      chk(n, 0);
      meas <= HI;
      cyc(8);
      chk(link.pri_line, 1'b0);
      cyc(10);
      chk(link.pri_line, 1'b1);
      meas <= 16'h0;
      cyc(8);
      chk(link.pri_line, 1'b1);
      cyc(40);
      str  <= 1'b1;
      meas <= HI;
      cyc(15);
      meas <= 16'h0;
      cyc(30);
      chk(link.pri_line, 1'b1);
      cyc(35);
      chk(link.pri_line, 1'b0);
      dly <= 1'b0;
      str <= 1'b0;
      os  <= 1'b1;
      for (int t = 0; t < 2; t++) begin
         trail <= t[0];
         cyc(10);
         meas <= HI;
         hcount();
         chk(n, t ? 0 : 5);
         meas <= 16'h0;
         hcount();
         chk(n, t ? 5 : 0);
      end
      os    <= 1'b0;
      smode <= SOL_SEC_AND;
      meas  <= HI;
      bus(1'b1, OFS_CTRL, 32'h4);
      cyc(2 * BC + 10);
      chk(link.pri_line, 1'b0);
      bus(1'b1, OFS_CTRL, 32'hc);
      cyc(BC / 2);
      chk(link.pri_line, 1'b0);
      cyc(BC + 10);
      chk(link.pri_line, 1'b1);
      smode <= SOL_SEC_OR;
      meas  <= 16'h0;
      cyc(2 * BC + 10);
      chk(link.pri_line, 1'b1);
      bus(1'b1, OFS_CTRL, 32'h4);
      cyc(2 * BC + 10);
      chk(link.pri_line, 1'b0);
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(rd[3:2], 2'h1);
      bus(1'b1, OFS_CTRL, 32'h0);
      smode <= SOL_SEC_BIT;
      meas  <= HI;
      bit_run();
      chk(rd[ST_BIT_PRES], 1'b1);
      chk(rd[ST_BIT_FAIL], 1'b0);
      meas <= 16'h0;
      bit_run();
      chk(rd[ST_BIT_PRES], 1'b0);
      chk(rd[ST_BIT_FAIL], 1'b0);
      smode <= SOL_SEC_OFF;
      bit_run();
      chk(rd[ST_BIT_FAIL], 1'b1);
      smode <= SOL_SEC_TEACH;
      meas  <= 16'h0123;
      bus(1'b1, OFS_CTRL, 32'hc);
      cyc(6);
      meas <= 16'h0345;
      bus(1'b1, OFS_CTRL, 32'h4);
      cyc(6);
      chk(osp1, 16'h0123);
      chk(osp2, 16'h0345);
      bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b0, 8'h10, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h1);
      n = 0;
      while (iol !== 1'b1 && n < 2100) begin
         cyc(1);
         n++;
      end
      chk(n inside {[2000:2012]}, 1'b1);
      smode <= SOL_SEC_OUT;
      cyc(4);
      chk(link.sec_line, 1'b1);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd[1:0], 2'h2);
      meas <= 16'h0344;
      cyc(4);
      chk(link.sec_line, 1'b0);
      stop_test();
   end
endmodule // switching_output_logic_tb

// ===== verilog/sol_dev.sv
// Purpose: Sensor end: switching channels, timing, Boolean, test, teach
// Assumes: Measured value and configuration are on the sensor clock
// Notes:   IO-Link exchange itself lives elsewhere; only the mode flag
// Function
// - Primary output from switching channel, SIO or IO-Link
// - Start in SIO; wake-up pulse enters IO-Link
// - Second channel SIO only, input or output
// - Single-point high at setpoint, optional inversion
// - Window high between the two setpoints
// - Hysteresis: set at lower point, clear at upper
// - Delay both edges, combinable with stretch
// - Stretch holds each pulse a minimum time
// - One-shot pulse on leading or trailing edge
// - AND with secondary input, two ms late
// - OR with secondary input, two ms late
// - Test request answered by presence-coded handshake
// - Controller treats missing handshake as defect
// - Setpoints start at factory defaults
// - Teach rising edge captures first setpoint
// - Teach falling edge captures second setpoint
// - Mode and logic changes accepted while running
`timescale 1ns/1ps
module sol_dev #(
   parameter int CNT_W    = 16,
   parameter int BOOL_CYC = sol_pkg::BOOL_DLY_CYC
) (
   // Clock and reset
   input  wire logic                        I_MCLK,
   input  wire logic                        I_RST,
   // Link pins
   sol_link_if.dev                          LINK,
   // Measurement
   input  wire logic [sol_pkg::MEAS_W-1:0]  I_MEAS,
   // Channel configuration
   input  wire sol_pkg::sol_mode_t          I_MODE,
   input  wire logic                        I_INVERT,
   input  wire logic                        I_DLY_EN,
   input  wire logic                        I_STR_EN,
   input  wire logic                        I_OS_EN,
   input  wire logic                        I_OS_TRAIL,
   input  wire logic [CNT_W-1:0]            I_DLY_CNT,
   input  wire logic [CNT_W-1:0]            I_STR_CNT,
   input  wire logic [CNT_W-1:0]            I_OS_CNT,
   input  wire sol_pkg::sol_sec_t           I_SEC_MODE,
   // Setpoint load
   input  wire logic                        I_SP_WR,
   input  wire logic [sol_pkg::MEAS_W-1:0]  I_SP1,
   input  wire logic [sol_pkg::MEAS_W-1:0]  I_SP2,
   // Status
   output logic [sol_pkg::MEAS_W-1:0]       O_SP1,
   output logic [sol_pkg::MEAS_W-1:0]       O_SP2,
   output logic                             O_IOLINK,
   output logic                             O_CHAN
);
   import sol_pkg::*;

   localparam int BW = $clog2(BOOL_CYC + 1);

   typedef struct packed {
      logic              pw1;
      logic              pw2;
      logic              pw3;
      logic              sc1;
      logic              sc2;
      logic              sc3;
      logic              iol;
      logic [MEAS_W-1:0] sp1;
      logic [MEAS_W-1:0] sp2;
      logic              hys;
      logic              chan;
      logic              dly;
      logic              dly_h;
      logic              tmd;
      logic              sec_ch;
      logic              bool_o;
      logic              arm;
      logic              hs_v;
      logic [CNT_W-1:0]  dcnt;
      logic [CNT_W-1:0]  scnt;
      logic [CNT_W-1:0]  ocnt;
      logic [CNT_W-1:0]  hcnt;
      logic [BW-1:0]     bcnt;
   } sold_st_t;

   sold_st_t          q;
   sold_st_t          n;
   logic [MEAS_W-1:0] lo;
   logic [MEAS_W-1:0] hi;
   logic              base;
   logic              pol;
   logic              strd;
   logic              sw;
   logic              tgt;
   logic              rise;
   logic              fall;
   logic              sec_in;

   // Window bounds regardless of which setpoint is larger
   assign lo = (q.sp1 < q.sp2) ? q.sp1 : q.sp2;
   assign hi = (q.sp1 < q.sp2) ? q.sp2 : q.sp1;
   assign sec_in = q.sc2;
   assign rise = q.sc2 & ~q.sc3;
   assign fall = ~q.sc2 & q.sc3;

   always_comb begin
      unique case (I_MODE)
         SOL_SINGLE: base = (I_MEAS >= q.sp1);
         SOL_WINDOW: base = (I_MEAS >= lo) && (I_MEAS <= hi);
         SOL_HYST:   base = q.hys;
         default:    base = 1'b0;
      endcase
   end

   assign pol  = base ^ I_INVERT;
   assign strd = q.dly | (I_STR_EN && (q.scnt != '0));
   assign sw   = I_OS_EN ? (q.ocnt != '0) : q.tmd;

   always_comb begin
      unique case (I_SEC_MODE)
         SOL_SEC_AND: tgt = sw & sec_in;
         SOL_SEC_OR:  tgt = sw | sec_in;
         default:     tgt = sw;
      endcase
   end

   always_comb begin
      n = q;
      // Pins from the controller pass two flops first
      n.pw1 = LINK.pri_host_oe;
      n.pw2 = q.pw1;
      n.pw3 = q.pw2;
      n.sc1 = LINK.sec_line;
      n.sc2 = q.sc1;
      n.sc3 = q.sc2;
      // End of a master drive pulse is the wake-up
      if (q.pw3 && !q.pw2) begin
         n.iol = 1'b1;
      end
      // Lower bound sets, upper bound clears; between them hold
      if (I_MEAS <= lo) begin
         n.hys = 1'b1;
      end else if (I_MEAS >= hi) begin
         n.hys = 1'b0;
      end
      n.chan = base;
      // Delay stage: the count starts over if the level flips back
      if (!I_DLY_EN) begin
         n.dly  = pol;
         n.dcnt = '0;
      end else if (pol == q.dly) begin
         n.dcnt = '0;
      end else if (q.dcnt >= I_DLY_CNT) begin
         n.dly  = pol;
         n.dcnt = '0;
      end else begin
         n.dcnt = q.dcnt + 1'b1;
      end
      // Stretch stage reloads on every new rising edge
      n.dly_h = q.dly;
      if (q.dly && !q.dly_h) begin
         n.scnt = I_STR_CNT;
      end else if (q.scnt != '0) begin
         n.scnt = q.scnt - 1'b1;
      end
      n.tmd = strd;
      // One-shot on the chosen edge of the timed level
      if (I_OS_TRAIL ? (!strd && q.tmd) : (strd && !q.tmd)) begin
         n.ocnt = I_OS_CNT;
      end else if (q.ocnt != '0) begin
         n.ocnt = q.ocnt - 1'b1;
      end
      // Boolean result must stand still for two ms before it shows
      if (I_SEC_MODE != SOL_SEC_AND && I_SEC_MODE != SOL_SEC_OR) begin
         n.bool_o = tgt;
         n.bcnt   = '0;
      end else if (tgt == q.bool_o) begin
         n.bcnt = '0;
      end else if (q.bcnt >= BW'(BOOL_CYC - 1)) begin
         n.bool_o = tgt;
         n.bcnt   = '0;
      end else begin
         n.bcnt = q.bcnt + 1'b1;
      end
      n.sec_ch = (I_MEAS >= q.sp2);
      // Test request: answer after the request line is released
      // Edges of our own answer are ignored, else it would re-arm itself
      if (q.hcnt != '0) begin
         n.hcnt = q.hcnt - 1'b1;
      end else if (I_SEC_MODE == SOL_SEC_BIT && rise) begin
         n.arm = 1'b1;
      end else if (I_SEC_MODE == SOL_SEC_BIT && fall && q.arm) begin
         n.arm  = 1'b0;
         n.hcnt = CNT_W'(HS_CYC);
         n.hs_v = base;
      end
      if (I_SEC_MODE != SOL_SEC_BIT) begin
         n.arm = 1'b0;
      end
      // Teach edges win over a configuration load in the same cycle
      if (I_SP_WR) begin
         n.sp1 = I_SP1;
         n.sp2 = I_SP2;
      end
      if (I_SEC_MODE == SOL_SEC_TEACH && rise) begin
         n.sp1 = I_MEAS;
      end
      if (I_SEC_MODE == SOL_SEC_TEACH && fall) begin
         n.sp2 = I_MEAS;
      end
   end

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         q     <= '0;
         q.sp1 <= SP1_DEF;
         q.sp2 <= SP2_DEF;
      end else begin
         q <= n;
      end
   end

   // SIO drive only until IO-Link takes the line
   assign LINK.pri_dev_o  = q.bool_o;
   assign LINK.pri_dev_oe = ~q.iol;
   // Second pin drives the switching line in output mode, and the test handshake while it runs
   assign LINK.sec_dev_oe = (I_SEC_MODE == SOL_SEC_OUT)
                            | (q.hcnt != '0);
   assign LINK.sec_dev_o  = (I_SEC_MODE == SOL_SEC_OUT) ? q.sec_ch
                            : q.hs_v;
   assign O_SP1    = q.sp1;
   assign O_SP2    = q.sp2;
   assign O_IOLINK = q.iol;
   assign O_CHAN   = q.chan;
endmodule // sol_dev

// ===== verilog/sol_host.sv
// Purpose: Controller end: wake-up, test request, teach level, APB regs
// Assumes: APB master on the same clock
// Notes:   Teach and secondary sensor level come from the control word
`timescale 1ns/1ps
module sol_host #(
   parameter int TMO_CYC = sol_pkg::BTMO_CYC
) (
   // Clock and reset
   input  wire logic        I_MCLK,
   input  wire logic        I_RST,
   // APB slave
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic [31:0]      O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   // Link pins
   sol_link_if.host         LINK
);
   import sol_pkg::*;

   localparam int TW = $clog2(TMO_CYC + 1);

   typedef struct packed {
      logic [1:0]  pl;
      logic [1:0]  sl;
      logic [1:0]  doe;
      logic [1:0]  dov;
      sol_hst_t    st;
      logic [TW-1:0] cnt;
      logic        done;
      logic        pres;
      logic        fail;
      logic        drv;
      logic        lvl;
      logic [31:0] rd;
   } solh_st_t;

   solh_st_t q;
   solh_st_t n;
   logic     wr;
   logic     hit;

   assign hit = (I_PADDR == OFS_CTRL) || (I_PADDR == OFS_STATUS);
   assign wr  = I_PSEL & I_PENABLE & I_PWRITE & (I_PADDR == OFS_CTRL);

   always_comb begin
      n = q;
      // Device pins are synchronised; only the second stage is read
      n.pl  = {q.pl[0], LINK.pri_line};
      n.sl  = {q.sl[0], LINK.sec_line};
      n.doe = {q.doe[0], LINK.sec_dev_oe};
      n.dov = {q.dov[0], LINK.sec_dev_o};
      if (wr) begin
         n.drv = I_PWDATA[CTRL_SEC_DRV];
         n.lvl = I_PWDATA[CTRL_SEC_LVL];
      end
      unique case (q.st)
         SOL_H_IDLE: begin
            if (wr && I_PWDATA[CTRL_WAKE]) begin
               n.st  = SOL_H_WAKE;
               n.cnt = '0;
            end else if (wr && I_PWDATA[CTRL_BITREQ]) begin
               n.st   = SOL_H_REQ;
               n.cnt  = '0;
               n.done = 1'b0;
               n.fail = 1'b0;
               n.pres = 1'b0;
            end
         end
         SOL_H_WAKE: begin
            n.cnt = q.cnt + 1'b1;
            if (q.cnt >= TW'(WAKE_CYC - 1)) begin
               n.st = SOL_H_IDLE;
            end
         end
         SOL_H_REQ: begin
            n.cnt = q.cnt + 1'b1;
            if (q.cnt >= TW'(BREQ_CYC - 1)) begin
               n.st  = SOL_H_WAIT;
               n.cnt = '0;
            end
         end
         SOL_H_WAIT: begin
            n.cnt = q.cnt + 1'b1;
            if (q.doe[1]) begin
               n.st   = SOL_H_IDLE;
               n.done = 1'b1;
               n.pres = q.dov[1];
            end else if (q.cnt >= TW'(TMO_CYC - 1)) begin
               n.st   = SOL_H_IDLE;
               n.done = 1'b1;
               n.fail = 1'b1;
            end
         end
      endcase
      // Read data captured in the setup cycle, so it is a flop output
      if (I_PSEL && !I_PENABLE) begin
         n.rd = '0;
         if (I_PADDR == OFS_CTRL) begin
            n.rd[CTRL_SEC_DRV] = q.drv;
            n.rd[CTRL_SEC_LVL] = q.lvl;
         end else if (I_PADDR == OFS_STATUS) begin
            n.rd[ST_PRI_LVL]  = q.pl[1];
            n.rd[ST_SEC_LVL]  = q.sl[1];
            n.rd[ST_BIT_DONE] = q.done;
            n.rd[ST_BIT_PRES] = q.pres;
            n.rd[ST_BIT_FAIL] = q.fail;
            n.rd[ST_BUSY]     = (q.st != SOL_H_IDLE);
         end
      end
   end

   always_ff @(posedge I_MCLK or posedge I_RST) begin
      if (I_RST) begin
         q    <= '0;
         q.st <= SOL_H_IDLE;
      end else begin
         q <= n;
      end
   end

   assign O_PRDATA  = q.rd;
   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;
   assign LINK.pri_host_o  = 1'b1;
   assign LINK.pri_host_oe = (q.st == SOL_H_WAKE);
   // Teach: software moves the target, then toggles the level
   assign LINK.sec_host_o  = (q.st == SOL_H_REQ) | q.lvl;
   assign LINK.sec_host_oe = (q.st == SOL_H_REQ)
                             | (q.drv & (q.st != SOL_H_WAIT));
endmodule // sol_host
